/* File: rtl/ipr_pkg.sv */
// package for the interrupt pin readback register
// assumes a two-function config space reached by byte offset
`default_nettype none
package ipr_pkg;
    // config byte offset of the interrupt pin register
    localparam logic [7:0] IPR_PIN_OFFSET   = 8'h3D;
    // pin codes as seen by software
    localparam logic [7:0] IPR_PIN_NONE     = 8'h00;
    localparam logic [7:0] IPR_PIN_INTA     = 8'h01;
    localparam logic [7:0] IPR_PIN_INTB     = 8'h02;
    // pin code field position and width inside the byte
    localparam int         IPR_CODE_LSB     = 0;
    localparam int         IPR_CODE_MSB     = 1;
    // bit positions of the two controls in their home registers
    localparam int         IPR_TIE_BIT      = 29;
    localparam int         IPR_MODE_LSB     = 1;
    localparam int         IPR_MODE_MSB     = 2;
    // signalling mode that carries no pci interrupt pin at all
    localparam logic [1:0] IPR_MODE_NO_PIN  = 2'h3;
    // reset value of the read data and answer
    localparam logic [7:0] IPR_RDATA_RESET  = 8'h00;
    // cycles from a taken request to its answer
    localparam int         IPR_ANSWER_LAT   = 1;

    typedef enum logic {
        IPR_FUNC0,
        IPR_FUNC1
    } ipr_func_e;
endpackage : ipr_pkg
`default_nettype wire

/* File: rtl/ipr_pin_calc.sv */
// combinational pin code for one function
// assumes the tie control and mode field arrive already stable
`default_nettype none
module ipr_pin_calc (
    input  wire logic               tie_ctrl,
    input  wire logic [1:0]         mode_field,
    input  wire ipr_pkg::ipr_func_e func_sel,
    output logic [7:0]              pin_code
);
    import ipr_pkg::*;

    // tie first: with it set both functions read INTA whatever the mode
    always_comb begin
        if (tie_ctrl) begin
            pin_code = IPR_PIN_INTA;  // RULE_03
        end else if (mode_field == IPR_MODE_NO_PIN) begin
            pin_code = IPR_PIN_NONE;  // RULE_01
        end else if (func_sel == IPR_FUNC1) begin
            pin_code = IPR_PIN_INTB;  // RULE_04
        end else begin
            pin_code = IPR_PIN_INTA;  // RULE_04
        end
    end
endmodule : ipr_pin_calc
`default_nettype wire

/* File: rtl/ipr_interrupt_pin_readback.sv */
// config-space interrupt pin register for a two-function controller
// assumes a config access port already decoded to this device and
// the tie control and mode fields supplied from their home registers
// Function
// [RULE_01] readback per function follows that function's signalling mode field
// [RULE_02] readback also depends on the interrupt tie control
// [RULE_03] tie set: both functions read 01h
// [RULE_04] tie clear: function 0 reads 01h, function 1 reads 02h
// [RULE_05] writes ignored; bits 7 to 2 read zero, code in bits 1 and 0
`default_nettype none
module ipr_interrupt_pin_readback (
    input  wire logic               clk,
    input  wire logic               rst,
    input  wire logic               cfg_req,
    input  wire logic               cfg_we,
    input  wire ipr_pkg::ipr_func_e cfg_func,
    input  wire logic [7:0]         cfg_addr,
    input  wire logic [7:0]         cfg_wdata,
    input  wire logic               interrupt_tie_control,
    input  wire logic [1:0]         interrupt_signaling_mode_field_f0,
    input  wire logic [1:0]         interrupt_signaling_mode_field_f1,
    output logic                    cfg_ack,
    output logic [7:0]              cfg_rdata
);
    import ipr_pkg::*;

    logic       hit;
    logic       rd_hit;
    logic [1:0] sel_mode;
    logic [7:0] pin_code;
    logic [7:0] nxt_rdata;
    logic       ack_ff;
    logic [7:0] rdata_ff;
    logic       wdata_unused;

    // the written byte never lands anywhere; the register has no storage
    assign wdata_unused = ^cfg_wdata;

    function automatic logic offset_hit(input logic [7:0] addr);
        return addr == IPR_PIN_OFFSET;
    endfunction : offset_hit

    // used by the checks only; the answer path tests the mode in the calc unit
    function automatic logic no_pin(input logic [1:0] mode);
        return mode == IPR_MODE_NO_PIN;
    endfunction : no_pin

    assign hit    = cfg_req && offset_hit(cfg_addr);
    assign rd_hit = hit && !cfg_we;

    // each function has its own device control copy
    always_comb begin
        case (cfg_func)
            IPR_FUNC0: sel_mode = interrupt_signaling_mode_field_f0;  // RULE_01
            IPR_FUNC1: sel_mode = interrupt_signaling_mode_field_f1;  // RULE_01
            default:   sel_mode = interrupt_signaling_mode_field_f0;
        endcase
    end

    ipr_pin_calc u_calc (
        .tie_ctrl   (interrupt_tie_control),  // RULE_02
        .mode_field (sel_mode),
        .func_sel   (cfg_func),
        .pin_code   (pin_code)
    );

    // only the two code bits are ever passed; the upper six stay zero
    always_comb begin
        nxt_rdata = IPR_RDATA_RESET;
        if (rd_hit) begin
            nxt_rdata[IPR_CODE_MSB:IPR_CODE_LSB] = pin_code[IPR_CODE_MSB:IPR_CODE_LSB]; // RULE_05
        end
    end

    // writes are acknowledged like reads so the config cycle completes
    always_ff @(posedge clk) begin
        if (rst) begin
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= hit;  // RULE_05
        end
    end

    // data holds zero between answers so a stale code cannot be sampled
    always_ff @(posedge clk) begin
        if (rst) begin
            rdata_ff <= IPR_RDATA_RESET;
        end else begin
            rdata_ff <= nxt_rdata;  // RULE_03 RULE_04
        end
    end

    assign cfg_ack   = ack_ff;
    assign cfg_rdata = rdata_ff;

    // checks sample the controls in the request cycle, like the answer path
    tie_both_inta_a: assert property (  // RULE_03
        @(posedge clk) disable iff (rst)
        rd_hit && interrupt_tie_control
        |=> cfg_ack && (cfg_rdata == IPR_PIN_INTA)
    ) else $error("tie set but pin code is not INTA");

    tie_beats_mode_a: assert property (  // RULE_03
        @(posedge clk) disable iff (rst)
        rd_hit && interrupt_tie_control && no_pin(sel_mode)
        |=> cfg_rdata == IPR_PIN_INTA
    ) else $error("no-pin mode overrode the tie control");

    tie_func0_inta_a: assert property (  // RULE_03
        @(posedge clk) disable iff (rst)
        rd_hit && interrupt_tie_control && (cfg_func == IPR_FUNC0)
        |=> cfg_ack && (cfg_rdata == IPR_PIN_INTA)
    ) else $error("tie set but function 0 did not read INTA");

    tie_func1_inta_a: assert property (  // RULE_03
        @(posedge clk) disable iff (rst)
        rd_hit && interrupt_tie_control && (cfg_func == IPR_FUNC1)
        |=> cfg_ack && (cfg_rdata == IPR_PIN_INTA)
    ) else $error("tie set but function 1 did not read INTA");

    untied_func0_a: assert property (  // RULE_04
        @(posedge clk) disable iff (rst)
        rd_hit && !interrupt_tie_control && (cfg_func == IPR_FUNC0)
            && (interrupt_signaling_mode_field_f0 != IPR_MODE_NO_PIN)
        |=> cfg_rdata == IPR_PIN_INTA
    ) else $error("function 0 untied did not read INTA");

    untied_func1_a: assert property (  // RULE_04
        @(posedge clk) disable iff (rst)
        rd_hit && !interrupt_tie_control && (cfg_func == IPR_FUNC1)
            && (interrupt_signaling_mode_field_f1 != IPR_MODE_NO_PIN)
        |=> cfg_rdata == IPR_PIN_INTB
    ) else $error("function 1 untied did not read INTB");

    tie_affects_a: assert property (  // RULE_02
        @(posedge clk) disable iff (rst)
        rd_hit && (cfg_func == IPR_FUNC1)
            && (interrupt_signaling_mode_field_f1 != IPR_MODE_NO_PIN)
        |=> cfg_rdata == ($past(interrupt_tie_control) ? IPR_PIN_INTA : IPR_PIN_INTB)
    ) else $error("tie control did not steer function 1 code");

    mode_per_func_a: assert property (  // RULE_01
        @(posedge clk) disable iff (rst)
        rd_hit && !interrupt_tie_control && (cfg_func == IPR_FUNC1)
            && (interrupt_signaling_mode_field_f1 == IPR_MODE_NO_PIN)
        |=> cfg_ack && (cfg_rdata == IPR_PIN_NONE)
    ) else $error("function 1 mode field not honoured");

    mode_func0_a: assert property (  // RULE_01
        @(posedge clk) disable iff (rst)
        rd_hit && !interrupt_tie_control && (cfg_func == IPR_FUNC0)
            && no_pin(interrupt_signaling_mode_field_f0)
        |=> cfg_ack && (cfg_rdata == IPR_PIN_NONE)
    ) else $error("function 0 mode field not honoured");

    own_field_f0_a: assert property (  // RULE_01
        @(posedge clk) disable iff (rst)
        rd_hit && !interrupt_tie_control && (cfg_func == IPR_FUNC0)
            && !no_pin(interrupt_signaling_mode_field_f0)
            && no_pin(interrupt_signaling_mode_field_f1)
        |=> cfg_rdata == IPR_PIN_INTA
    ) else $error("function 0 read took the function 1 mode field");

    own_field_f1_a: assert property (  // RULE_01
        @(posedge clk) disable iff (rst)
        rd_hit && !interrupt_tie_control && (cfg_func == IPR_FUNC1)
            && !no_pin(interrupt_signaling_mode_field_f1)
            && no_pin(interrupt_signaling_mode_field_f0)
        |=> cfg_rdata == IPR_PIN_INTB
    ) else $error("function 1 read took the function 0 mode field");

    upper_zero_a: assert property (  // RULE_05
        @(posedge clk) disable iff (rst)
        cfg_ack |-> cfg_rdata[7:2] == 6'h00
    ) else $error("upper interrupt pin bits not zero");

    write_ignored_a: assert property (  // RULE_05
        @(posedge clk) disable iff (rst)
        hit && cfg_we |=> cfg_ack && (cfg_rdata == IPR_RDATA_RESET)
    ) else $error("write to interrupt pin returned data");

    miss_silent_a: assert property (  // RULE_05
        @(posedge clk) disable iff (rst)
        !hit |=> !cfg_ack ##0 cfg_rdata == IPR_RDATA_RESET
    ) else $error("answer without a hit on the pin offset");

    refused_offset_a: assert property (  // RULE_05
        @(posedge clk) disable iff (rst)
        cfg_req && !offset_hit(cfg_addr)
        |=> !cfg_ack && (cfg_rdata == IPR_RDATA_RESET)
    ) else $error("answer for an offset that is not the pin register");

    ack_after_hit_a: assert property (  // RULE_05
        @(posedge clk) disable iff (rst)
        hit |=> cfg_ack
    ) else $error("hit on the pin offset was not acknowledged");

    ack_needs_hit_a: assert property (  // RULE_05
        @(posedge clk) disable iff (rst)
        cfg_ack |-> $past(hit)
    ) else $error("acknowledge without a request one cycle earlier");

    data_needs_read_a: assert property (  // RULE_05
        @(posedge clk) disable iff (rst)
        (cfg_rdata != IPR_RDATA_RESET) |-> $past(rd_hit)
    ) else $error("pin code shown without a read one cycle earlier");

    code_legal_a: assert property (  // RULE_04
        @(posedge clk) disable iff (rst)
        cfg_ack && (cfg_rdata != IPR_PIN_NONE)
        |-> (cfg_rdata == IPR_PIN_INTA) || (cfg_rdata == IPR_PIN_INTB)
    ) else $error("pin code is neither INTA nor INTB");

    stale_code_a: assert property (  // RULE_05
        @(posedge clk) disable iff (rst)
        rd_hit ##1 (cfg_req && cfg_we)
        |=> cfg_rdata == IPR_RDATA_RESET
    ) else $error("read code lingered into a write answer");

    // no disable here: this one watches the reset itself
    reset_quiet_a: assert property (  // RULE_05
        @(posedge clk)
        rst |=> !cfg_ack && (cfg_rdata == IPR_RDATA_RESET)
    ) else $error("answer not cleared by reset");
endmodule : ipr_interrupt_pin_readback
`default_nettype wire

/* File: verif/ipr_host_model.sv */
// host model issuing config accesses to the interrupt pin register
// assumes the caller steps it on falling clock edges
`default_nettype none
module ipr_host_model (
    input  wire logic       clk,
    output logic            cfg_req,
    output logic            cfg_we,
    output ipr_pkg::ipr_func_e cfg_func,
    output logic [7:0]      cfg_addr,
    output logic [7:0]      cfg_wdata
);
    timeunit 1ns;
    timeprecision 1ps;
    import ipr_pkg::*;
    initial begin
        cfg_req   = 1'b0;
        cfg_we    = 1'b0;
        cfg_func  = IPR_FUNC0;
        cfg_addr  = 8'h00;
        cfg_wdata = 8'h00;
    end
    task automatic put(input logic w, input ipr_func_e f, input logic [7:0] a,
                       input logic [7:0] d);
        cfg_req   = 1'b1;
        cfg_we    = w;
        cfg_func  = f;
        cfg_addr  = a;
        cfg_wdata = d;
    endtask : put
    // on release the address and write data flip so a stale value never looks valid
    task automatic drop();
        cfg_req   = 1'b0;
        cfg_addr  = ~cfg_addr;
        cfg_wdata = ~cfg_wdata;
    endtask : drop
endmodule : ipr_host_model
`default_nettype wire

/* File: verif/interrupt_pin_readback_bench.sv */
// self-checking bench for the interrupt pin readback register
// assumes one-cycle ack and registered read data as handed over
`default_nettype none
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin mismatches++; \
    $display("[FAIL] %s exp %0h got %0h", n, e, g); end end
module interrupt_pin_readback_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import ipr_pkg::*;
    logic       clk, rst, tie, ack, req, we;
    logic [1:0] m0, m1;
    logic [7:0] rdata, addr, wdata;
    logic [31:0] r;
    ipr_func_e  func;
    int         mismatches = 0;
    int         checks = 0;
    int         seed = 73494;
    ipr_host_model host (.clk(clk), .cfg_req(req), .cfg_we(we), .cfg_func(func),
                         .cfg_addr(addr), .cfg_wdata(wdata));
    ipr_interrupt_pin_readback dut (.clk(clk), .rst(rst), .cfg_req(req), .cfg_we(we),
        .cfg_func(func), .cfg_addr(addr), .cfg_wdata(wdata),
        .interrupt_tie_control(tie), .interrupt_signaling_mode_field_f0(m0),
        .interrupt_signaling_mode_field_f1(m1), .cfg_ack(ack), .cfg_rdata(rdata));
    // the tie wins; with it clear, mode 3 means no pin at all
    function automatic logic [7:0] pin(input logic w, input ipr_func_e f,
                                       input logic [7:0] a);
        logic [1:0] m;
        m = (f == IPR_FUNC1) ? m1 : m0;
        if (w || a != 8'h3D) return 8'h00;
        if (tie) return 8'h01;
        if (m == 2'h3) return 8'h00;
        return (f == IPR_FUNC0) ? 8'h01 : 8'h02;
    endfunction : pin
    task automatic acc(input logic w, input ipr_func_e f, input logic [7:0] a);
        logic [7:0] e;
        e = pin(w, f, a);
        host.put(w, f, a, r[15:8]);
        @(negedge clk);
        `CHK("ack", (a == 8'h3D), ack)
        `CHK("rdata", e, rdata)
    endtask : acc
    task automatic idle();
        host.drop();
        @(negedge clk);
        `CHK("idle ack", 1'b0, ack)
        `CHK("idle rdata", 8'h00, rdata)
    endtask : idle
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : end_of_test
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    initial begin
        #20000;
        mismatches++;
        end_of_test();
    end
    initial begin
        rst = 1'b1;
        tie = 1'b0;
        m0  = 2'h0;
        m1  = 2'h0;
        r   = 32'h0;
        repeat (10) @(negedge clk);
        rst = 1'b0;
        idle();
        for (int i = 0; i < 16; i++) begin
            tie = i[3];
            m0  = i[1:0];
            m1  = i[1:0];
            acc(1'b0, ipr_func_e'(i[2]), 8'h3D);
        end
        // back to back mixes of reads, writes, misses and split modes
        for (int i = 0; i < 300; i++) begin
            r   = $random(seed);
            tie = r[0];
            m0  = r[2:1];
            m1  = r[4:3];
            acc(r[5], ipr_func_e'(r[6]), r[7] ? 8'h3D : r[23:16]);
            if (r[24]) idle();
        end
        // a reset landing on a live read must swallow its answer
        host.put(1'b0, IPR_FUNC1, 8'h3D, 8'h00);
        rst = 1'b1;
        @(negedge clk);
        `CHK("reset ack", 1'b0, ack)
        `CHK("reset rdata", 8'h00, rdata)
        rst = 1'b0;
        idle();
        tie = 1'b0;
        m1  = 2'h0;
        acc(1'b0, IPR_FUNC1, 8'h3D);
        end_of_test();
    end
endmodule : interrupt_pin_readback_bench
`default_nettype wire
